//--- core/pm_seq_defines.svh
// Timing counts and power thresholds shared by both ends of the power link.
`ifndef PM_SEQ_DEFINES_SVH
`define PM_SEQ_DEFINES_SVH

// Slow reference clock rate in hertz.
`define PM_REF_CLK_HZ       32768
// Power-enable debounce time in microseconds.
`define PM_DEBOUNCE_US      1000
// Least low time of the power enable that makes a shutdown event, in microseconds.
`define PM_MIN_LOW_US       100
// Least times round up to whole reference ticks.
`define PM_DEBOUNCE_TICKS   ((`PM_DEBOUNCE_US * `PM_REF_CLK_HZ + 999999) / 1000000)
`define PM_MIN_LOW_TICKS    ((`PM_MIN_LOW_US * `PM_REF_CLK_HZ + 999999) / 1000000)
// Width of the slow tick counters.
`define PM_TICK_W           8

// Input power samples are in milliwatts.
`define PM_POWER_W          16
`define PM_AVG_SAMPLES      512
`define PM_WARN_15W_MW      15000
`define PM_WARN_20W_MW      20000
`define PM_CRIT_MW          25000

`endif

//--- core/pm_seq_pkg.sv
// Types shared by the module-side and carrier-side power sequencers.
package pm_seq_pkg;

    // Power states of the module.
    typedef enum logic [1:0] {
        PWR_OFF   = 2'b00,
        PWR_ON    = 2'b01,
        PWR_SLEEP = 2'b10
    } power_state_t;

    // Power budget selected by software.
    typedef enum logic {
        MODE_15W = 1'b0,
        MODE_20W = 1'b1
    } power_mode_t;

endpackage : pm_seq_pkg

//--- core/pm_link_if.sv
// Connector signals between the compute module and the carrier board.
`timescale 1ns/1ps
interface pm_link_if;
    logic power_enable;        // Carrier to module, high means on.
    logic shutdown_request_n;  // Module to carrier, low asks for shutdown.
    logic mod_rst_out;         // Module open-drain data, always low.
    logic mod_rst_oe;          // Module pulls the reset line low.
    logic car_rst_out;         // Carrier open-drain data, always low.
    logic car_rst_oe;          // Carrier pulls the reset line low.
    logic module_reset_n;      // Resolved wire level with its pull-up.

    // The line is pulled up; any enabled low driver wins.
    assign module_reset_n = !((mod_rst_oe && !mod_rst_out) || (car_rst_oe && !car_rst_out));

    modport device (
        input  power_enable,
        input  module_reset_n,
        output shutdown_request_n,
        output mod_rst_out,
        output mod_rst_oe
    );

    modport carrier (
        output power_enable,
        input  module_reset_n,
        input  shutdown_request_n,
        output car_rst_out,
        output car_rst_oe
    );
endinterface : pm_link_if

//--- core/carrier_power_ctrl.sv
// Carrier-board end of the power sequencing link.
`timescale 1ns/1ps
`include "pm_seq_defines.svh"
module carrier_power_ctrl (
    // Clock and reset.
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // Link to the module.
    pm_link_if.carrier link,
    // User side.
    input  wire logic supply_good_in,
    input  wire logic power_on_req_in,
    input  wire logic power_off_req_in,
    input  wire logic reset_module_req_in,
    output logic      supply_enable_out,
    output logic      io_drive_en_out,
    output logic      shutdown_seen_out
);
    import pm_seq_pkg::*;

    logic rst_meta_q;
    logic rst_sync_q;
    logic req_meta_q;
    logic req_sync_q;
    logic enable_q;
    logic car_oe_q;

    // Both inputs from the module pass two flops before any use.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
            req_meta_q <= 1'b1;
            req_sync_q <= 1'b1;
        end else begin
            rst_meta_q <= link.module_reset_n;
            rst_sync_q <= rst_meta_q;
            req_meta_q <= link.shutdown_request_n;
            req_sync_q <= req_meta_q;
        end
    end

    // The enable doubles as supply-good, so it never rises on a bad supply.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= 1'b0;
        end else if (power_off_req_in || !req_sync_q || !supply_good_in) begin
            enable_q <= 1'b0;
        end else if (power_on_req_in) begin
            enable_q <= 1'b1;
        end
    end

    // Supplies follow the reset line: on after release, off only once asserted.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            supply_enable_out <= 1'b0;
        end else if (!rst_sync_q) begin
            supply_enable_out <= 1'b0;
        end else if (enable_q) begin
            supply_enable_out <= 1'b1;
        end
    end

    // Interface drivers stop the cycle after reset is seen low.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_drive_en_out   <= 1'b0;
            shutdown_seen_out <= 1'b0;
            car_oe_q          <= 1'b0;
        end else begin
            io_drive_en_out   <= rst_sync_q && supply_enable_out;
            shutdown_seen_out <= !req_sync_q;
            car_oe_q          <= reset_module_req_in;
        end
    end

    assign link.power_enable = enable_q;
    assign link.car_rst_out  = 1'b0;
    assign link.car_rst_oe   = car_oe_q;

endmodule : carrier_power_ctrl

//--- core/module_power_sequencer.sv
// Module end of the power link: power states, shutdown requests and throttling.
`timescale 1ns/1ps
`include "pm_seq_defines.svh"
module module_power_sequencer #(
    parameter int IO_W    = 8,
    parameter int POWER_W = `PM_POWER_W,
    parameter int AVG_N   = `PM_AVG_SAMPLES
) (
    // Clock and reset.
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // Link to the carrier board.
    pm_link_if.device                   link,
    // Slow reference clock, sampled as a level.
    input  wire logic                   slow_ref_in,
    // Internal power-up and shutdown sources.
    input  wire logic                   powerup_done_in,
    input  wire logic                   sw_shutdown_in,
    input  wire logic                   thermal_trip_in,
    input  wire logic                   undervolt_in,
    // Sleep control and wake sources.
    input  wire logic                   sleep_req_in,
    input  wire logic                   deep_sleep_req_in,
    input  wire logic                   timer_wake_in,
    input  wire logic                   vbus_wake_in,
    input  wire logic                   card_detect_wake_in,
    input  wire logic                   pin_wake_in,
    input  wire logic                   temp_limit_in,
    // Input power monitor.
    input  pm_seq_pkg::power_mode_t     power_mode_in,
    input  wire logic                   sample_valid_in,
    input  wire logic [POWER_W-1:0]     sample_mw_in,
    // Module I/O values and state.
    input  wire logic [IO_W-1:0]        io_value_in,
    output logic      [IO_W-1:0]        io_value_out,
    output pm_seq_pkg::power_state_t    state_out,
    output logic                        regulator_shutdown_out,
    output logic                        sleep_indicator_n_out,
    output logic                        gpu_throttle_out,
    output logic                        cpu_throttle_out
);
    import pm_seq_pkg::*;

    localparam int DEB_TICKS = `PM_DEBOUNCE_TICKS;
    localparam int LOW_TICKS = `PM_MIN_LOW_TICKS;
    localparam int TW        = `PM_TICK_W;
    localparam int CNT_W     = $clog2(AVG_N);
    localparam int SUM_W     = POWER_W + CNT_W;

    power_state_t     state_q;
    logic             ref_meta_q;
    logic             ref_sync_q;
    logic             ref_last_q;
    logic             tick;
    logic             en_meta_q;
    logic             en_sync_q;
    logic             en_deb_q;
    logic             en_deb_last_q;
    logic [TW-1:0]    deb_cnt_q;
    logic [TW-1:0]    low_cnt_q;
    logic             low_event;
    logic             boot_done_q;
    logic             deep_q;
    logic             req_n_q;
    logic             rst_oe_q;
    logic             wake;
    logic [CNT_W-1:0] smp_cnt_q;
    logic [SUM_W-1:0] sum_q;
    logic [SUM_W-1:0] warn_limit;

    // Scales a milliwatt threshold to a window sum.
    function automatic logic [SUM_W-1:0] window_limit(input int mw);
        window_limit = SUM_W'(mw * AVG_N);
    endfunction : window_limit

    // The slow reference and the power enable pass two flops; the edge detector reads the second and its delayed copy.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_meta_q <= 1'b0;
            ref_sync_q <= 1'b0;
            ref_last_q <= 1'b0;
            en_meta_q  <= 1'b0;
            en_sync_q  <= 1'b0;
        end else begin
            ref_meta_q <= slow_ref_in;
            ref_sync_q <= ref_meta_q;
            ref_last_q <= ref_sync_q;
            en_meta_q  <= link.power_enable;
            en_sync_q  <= en_meta_q;
        end
    end

    // One pulse per rising edge of the slow reference.
    assign tick = ref_sync_q && !ref_last_q;

    // The debounced level flips only after a full stable millisecond.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_deb_q      <= 1'b0;
            en_deb_last_q <= 1'b0;
            deb_cnt_q     <= '0;
        end else begin
            en_deb_last_q <= en_deb_q;
            if (en_sync_q == en_deb_q) begin
                deb_cnt_q <= '0;
            end else if (tick) begin
                if (deb_cnt_q >= TW'(DEB_TICKS - 1)) begin
                    en_deb_q  <= en_sync_q;
                    deb_cnt_q <= '0;
                end else begin
                    deb_cnt_q <= deb_cnt_q + 1'b1;
                end
            end
        end
    end

    // Low time of the enable, saturating at the event threshold.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cnt_q <= '0;
        end else if (en_sync_q) begin
            low_cnt_q <= '0;
        end else if (tick && low_cnt_q < TW'(LOW_TICKS)) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    assign low_event = (low_cnt_q >= TW'(LOW_TICKS)) && (state_q == PWR_ON);

    // A dropped enable in SLEEP also wakes so the OFF path runs from ON.
    assign wake = timer_wake_in || vbus_wake_in || card_detect_wake_in || pin_wake_in
                  || temp_limit_in || thermal_trip_in || !en_deb_q;

    // Power state machine.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= PWR_OFF;
        end else begin
            case (state_q)
                PWR_OFF: begin
                    if (en_deb_q && !en_deb_last_q) begin
                        state_q <= PWR_ON;
                    end
                end
                PWR_ON: begin
                    if (!en_deb_q) begin
                        state_q <= PWR_OFF;
                    end else if (sleep_req_in) begin
                        state_q <= PWR_SLEEP;
                    end
                end
                PWR_SLEEP: begin
                    if (wake) begin
                        state_q <= PWR_ON;
                    end
                end
                default: begin
                    state_q <= PWR_OFF;
                end
            endcase
        end
    end

    // Boot completion survives sleep, so resume needs no new power-up.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            boot_done_q <= 1'b0;
        end else if (state_q == PWR_OFF) begin
            boot_done_q <= 1'b0;
        end else if (state_q == PWR_ON && powerup_done_in) begin
            boot_done_q <= 1'b1;
        end
    end

    // Deep sleep is a sub-state of SLEEP and ends with it.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            deep_q <= 1'b0;
        end else if (state_q != PWR_SLEEP || wake) begin
            deep_q <= 1'b0;
        end else if (deep_sleep_req_in) begin
            deep_q <= 1'b1;
        end
    end

    // Shutdown request: thermal in any state, the others only while on.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_n_q <= 1'b1;
        end else if (thermal_trip_in) begin
            req_n_q <= 1'b0;
        end else if (state_q == PWR_ON && (sw_shutdown_in || undervolt_in || low_event)) begin
            req_n_q <= 1'b0;
        end else if (state_q == PWR_OFF) begin
            req_n_q <= 1'b1;
        end
    end

    // Reset is held low in OFF and until power-up completes.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_oe_q <= 1'b1;
        end else if (!en_deb_q || state_q == PWR_OFF) begin
            rst_oe_q <= 1'b1;
        end else if (boot_done_q || (state_q == PWR_ON && powerup_done_in)) begin
            rst_oe_q <= 1'b0;
        end
    end

    // Supply shutdown starts only once the enable is really gone.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            regulator_shutdown_out <= 1'b1;
        end else begin
            regulator_shutdown_out <= (state_q == PWR_OFF) || !en_deb_q;
        end
    end

    // Outputs freeze in SLEEP and drop low the cycle after the module asserts reset.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_value_out <= '0;
        end else if (rst_oe_q) begin
            io_value_out <= '0;
        end else if (state_q != PWR_SLEEP) begin
            io_value_out <= io_value_in;
        end
    end

    // Status outputs.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_out             <= PWR_OFF;
            sleep_indicator_n_out <= 1'b1;
        end else begin
            state_out             <= state_q;
            sleep_indicator_n_out <= !deep_q;
        end
    end

    // Warning threshold depends on the power mode; critical does not.
    assign warn_limit = (power_mode_in == MODE_20W) ? window_limit(`PM_WARN_20W_MW)
                                                    : window_limit(`PM_WARN_15W_MW);

    // Block average: a window sum compared once per AVG_N samples avoids a divider.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smp_cnt_q        <= '0;
            sum_q            <= '0;
            gpu_throttle_out <= 1'b0;
            cpu_throttle_out <= 1'b0;
        end else if (sample_valid_in) begin
            cpu_throttle_out <= sample_mw_in > POWER_W'(`PM_CRIT_MW);
            if (smp_cnt_q == CNT_W'(AVG_N - 1)) begin
                gpu_throttle_out <= (sum_q + SUM_W'(sample_mw_in) > warn_limit)
                                    || sample_mw_in > POWER_W'(`PM_CRIT_MW);
                sum_q            <= '0;
                smp_cnt_q        <= '0;
            end else begin
                gpu_throttle_out <= gpu_throttle_out && !(sample_mw_in <= POWER_W'(`PM_CRIT_MW)
                                    && cpu_throttle_out && smp_cnt_q == '0);
                sum_q            <= sum_q + SUM_W'(sample_mw_in);
                smp_cnt_q        <= smp_cnt_q + 1'b1;
            end
        end
    end

    assign link.shutdown_request_n = req_n_q;
    assign link.mod_rst_out        = 1'b0;
    assign link.mod_rst_oe         = rst_oe_q;

endmodule : module_power_sequencer

//--- verif/pm_seq_asserts.sv
// Concurrent checks on the power link signals between the module and the carrier.
`timescale 1ns/1ps
module pm_seq_asserts #(
    parameter int TICK_CYC = 4
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Link signals.
    input wire logic power_enable,
    input wire logic shutdown_request_n,
    input wire logic mod_rst_out,
    input wire logic mod_rst_oe,
    input wire logic car_rst_out,
    input wire logic module_reset_n
);
    // A debounced change needs at least this many core cycles of a stable enable.
    localparam int DEB_CYC  = 31 * TICK_CYC;
    localparam int LATE_CYC = 40 * TICK_CYC;

    logic [9:0] hi_cnt_q;
    logic [9:0] lo_cnt_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Cycles the enable has stood high; it saturates so a long run never wraps.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_cnt_q <= 10'h000;
        end else if (!power_enable) begin
            hi_cnt_q <= 10'h000;
        end else if (hi_cnt_q != 10'h3ff) begin
            hi_cnt_q <= hi_cnt_q + 10'h001;
        end
    end

    // Cycles the enable has stood low, saturating as well.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lo_cnt_q <= 10'h000;
        end else if (power_enable) begin
            lo_cnt_q <= 10'h000;
        end else if (lo_cnt_q != 10'h3ff) begin
            lo_cnt_q <= lo_cnt_q + 10'h001;
        end
    end

    // A shutdown request must be answered by the carrier within a few cycles.
    sequence req_seen;
        $fell(shutdown_request_n);
    endsequence
    sequence enable_gone;
        ##[0:4] !power_enable;
    endsequence

    chk_request_drops_enable: assert property (req_seen |-> enable_gone)
        else $error("enable stayed high after a shutdown request");
    chk_no_enable_on_request: assert property ((!shutdown_request_n)[*4] |-> !$rose(power_enable))
        else $error("enable raised while shutdown was requested");
    chk_release_after_debounce: assert property ($rose(module_reset_n) |-> hi_cnt_q >= DEB_CYC)
        else $error("reset released before the enable was debounced");
    chk_reset_after_drop: assert property (lo_cnt_q >= LATE_CYC |-> !module_reset_n)
        else $error("reset line still high long after enable dropped");
    chk_request_latched: assert property (!shutdown_request_n && power_enable |=> !shutdown_request_n)
        else $error("shutdown request withdrawn while enable is high");
    chk_open_drain_low: assert property (!mod_rst_out && !car_rst_out)
        else $error("open-drain reset data driven high");
    chk_off_holds_reset: assert property (!power_enable && !module_reset_n |=> !module_reset_n)
        else $error("reset released without an enable");
    chk_off_only_debounced: assert property ($rose(mod_rst_oe) |-> lo_cnt_q >= DEB_CYC)
        else $error("module entered off before the enable loss was debounced");
endmodule : pm_seq_asserts

//--- verif/tb_module_power_sequencer.sv
// Testbench joining the module and carrier sequencers across the power link.
`timescale 1ns/1ps
module tb_module_power_sequencer;
    import pm_seq_pkg::*;
    localparam int TICK_CYC = 4;

    logic         core_clk_in = 1'b0;
    logic         rst_n_in    = 1'b0;
    logic         slow_ref    = 1'b0;
    logic         sup_good, on_req, off_req, rst_req, pu_done, sw_sd, therm, uv, slp, dslp, sv;
    logic [4:0]   wake;
    power_mode_t  mode;
    logic [15:0]  mw;
    logic [7:0]   iov, io_o;
    power_state_t st;
    logic         reg_sd, slp_ind_n, gpu_th, cpu_th, sup_en, io_en, sd_seen;
    int           err_total  = 0;
    int           n_compared = 0;

    pm_link_if link ();

    // Core clock, and a free reference at a quarter rate so the debounce stays short.
    always #20 core_clk_in = ~core_clk_in;
    always #80 slow_ref = ~slow_ref;

    module_power_sequencer u_module_power_sequencer (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link.device), .slow_ref_in(slow_ref),
        .powerup_done_in(pu_done), .sw_shutdown_in(sw_sd), .thermal_trip_in(therm), .undervolt_in(uv),
        .sleep_req_in(slp), .deep_sleep_req_in(dslp), .timer_wake_in(wake[0]), .vbus_wake_in(wake[1]),
        .card_detect_wake_in(wake[2]), .pin_wake_in(wake[3]), .temp_limit_in(wake[4]),
        .power_mode_in(mode), .sample_valid_in(sv), .sample_mw_in(mw), .io_value_in(iov),
        .io_value_out(io_o), .state_out(st), .regulator_shutdown_out(reg_sd),
        .sleep_indicator_n_out(slp_ind_n), .gpu_throttle_out(gpu_th), .cpu_throttle_out(cpu_th));

    carrier_power_ctrl u_carrier_power_ctrl (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link.carrier), .supply_good_in(sup_good),
        .power_on_req_in(on_req), .power_off_req_in(off_req), .reset_module_req_in(rst_req),
        .supply_enable_out(sup_en), .io_drive_en_out(io_en), .shutdown_seen_out(sd_seen));

    pm_seq_asserts #(.TICK_CYC(TICK_CYC)) u_pm_seq_asserts (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .power_enable(link.power_enable),
        .shutdown_request_n(link.shutdown_request_n), .mod_rst_out(link.mod_rst_out),
        .mod_rst_oe(link.mod_rst_oe), .car_rst_out(link.car_rst_out), .module_reset_n(link.module_reset_n));

    // Inputs always change one step after the edge, never racing the sampling edge.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : step

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compared=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // Bounded wait for a state; running out counts as a mismatch and ends the run.
    task automatic wait_st(input power_state_t s);
        for (int i = 0; i < 600 && st !== s; i++) step(1);
        if (st !== s) begin
            err_total++;
            wrap_up();
        end
    endtask : wait_st

    // Back-to-back power samples, one per cycle.
    task automatic burst(input logic [15:0] v, input int n);
        sv = 1'b1;
        mw = v;
        step(n);
        sv = 1'b0;
        step(2);
    endtask : burst

    task automatic power_up();
        on_req = 1'b1;
        wait_st(PWR_ON);
        check(link.module_reset_n, 1'b0);
        check(sup_en, 1'b0);
        pu_done = 1'b1;
        step(8);
        check(link.module_reset_n, 1'b1);
        check(sup_en, 1'b1);
        check(io_en, 1'b1);
    endtask : power_up

    // Main sequence.
    initial begin
        {sup_good, on_req, off_req, rst_req, pu_done, sw_sd, therm, uv, slp, dslp, sv} = '0;
        wake = '0;
        mode = MODE_15W;
        mw = '0;
        iov = 8'ha5;
        step(6);
        rst_n_in = 1'b1;
        step(2);
        check(st, PWR_OFF);
        check(link.module_reset_n, 1'b0);
        check(link.shutdown_request_n, 1'b1);
        on_req = 1'b1;
        step(200);
        check(link.power_enable, 1'b0);
        check(st, PWR_OFF);
        on_req = 1'b0;
        sup_good = 1'b1;
        sw_sd = 1'b1;
        uv = 1'b1;
        step(10);
        check(link.shutdown_request_n, 1'b1);
        sw_sd = 1'b0;
        uv = 1'b0;
        therm = 1'b1;
        step(3);
        check(link.shutdown_request_n, 1'b0);
        therm = 1'b0;
        step(3);
        check(link.shutdown_request_n, 1'b1);
        power_up();
        rst_req = 1'b1;
        step(5);
        check(link.module_reset_n, 1'b0);
        check(io_en, 1'b0);
        rst_req = 1'b0;
        step(5);
        check(link.module_reset_n, 1'b1);
        burst(16'h3a98, 512);
        check(gpu_th, 1'b0);
        burst(16'h3e80, 512);
        check(gpu_th, 1'b1);
        mode = MODE_20W;
        burst(16'h3e80, 512);
        check(gpu_th, 1'b0);
        burst(16'h4e21, 512);
        check(gpu_th, 1'b1);
        burst(16'h61a9, 1);
        check(cpu_th, 1'b1);
        burst(16'h61a8, 1);
        check(cpu_th, 1'b0);
        // All five wake inputs, each from deep sleep with the outputs frozen.
        for (int k = 0; k < 5; k++) begin
            iov = 8'ha5;
            slp = 1'b1;
            dslp = 1'b1;
            wait_st(PWR_SLEEP);
            slp = 1'b0;
            iov = 8'h5a;
            step(40);
            check(st, PWR_SLEEP);
            check(io_o, 8'ha5);
            check(slp_ind_n, 1'b0);
            wake[k] = 1'b1;
            wait_st(PWR_ON);
            wake[k] = 1'b0;
            dslp = 1'b0;
            step(3);
            check(io_o, 8'h5a);
            check(slp_ind_n, 1'b1);
            check(link.module_reset_n, 1'b1);
        end
        // Each shutdown source; the carrier re-powers once the request clears.
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: sw_sd = 1'b1;
                1: uv = 1'b1;
                2: therm = 1'b1;
                default: off_req = 1'b1;
            endcase
            step(40);
            check(link.shutdown_request_n, 1'b0);
            check(link.power_enable, 1'b0);
            check(sd_seen, 1'b1);
            check(st, PWR_ON);
            check(reg_sd, 1'b0);
            wait_st(PWR_OFF);
            check(link.module_reset_n, 1'b0);
            check(reg_sd, 1'b1);
            {sw_sd, uv, therm, off_req, pu_done} = '0;
            step(5);
            check(sup_en, 1'b0);
            check(io_en, 1'b0);
            power_up();
        end
        rst_n_in = 1'b0;
        step(2);
        check(st, PWR_OFF);
        check(link.module_reset_n, 1'b0);
        wrap_up();
    end
endmodule : tb_module_power_sequencer
